// File: include/qam_front_pkg.sv
// Contract
// R1: all four channels share one set of stage enables and bypasses.
// R2: the mapper takes one 8-bit word per symbol, gives a 5-bit I/Q pair.
// R3: a 3-bit field picks the mode; 000-001 annex B, 010-110 annex A/C.
// R4: the mapper reads only the low 4, 5, 6, 7 or 8 bits its mode needs.
// R5: coordinates span +-14 (64), +-11 (128), +-15 (16, 32, 256 points).
// R6: each coordinate leaves as a 5-bit two's-complement number.
// R7: annex B 64-point word 011101 maps to I = 6, Q = -10.
// R8: the input scaler acts only while the mapper is bypassed.
// R9: the scaler multiplies by the 8-bit gain code over 32.
// R10: the gain code resets to 0x20, unity gain.
// R11: scaler output rounds to 16 bits, saturating at 0x7FFF or 0x8000.
// R12: the pulse-shaping filter interpolates by 2.
// R13: roll-off 0.12, 0.13, 0.15 or 0.18 is chosen by bits 5:4.
// R14: the filter takes 5 bits and is switched by bit 6 of reg 0x06.
// R15: with the mapper bypassed the filter takes the word's 5 MSBs.
// R17: one word per symbol is taken, and pairs leave in order, none lost.
package qam_front_pkg;

   localparam logic [6:0] ADDR_DP_EN = 7'h06;
   localparam logic [6:0] ADDR_QAM_CFG = 7'h07;
   localparam logic [6:0] ADDR_GAIN = 7'h09;
   localparam logic [6:0] ADDR_STATUS = 7'h7F;

   localparam int MAP_EN_BIT = 7;
   localparam int PSF_EN_BIT = 6;
   localparam int MODE_LSB = 0;
   localparam int ROLL_LSB = 4;

   localparam logic [7:0] DP_EN_RST = 8'h00;
   localparam logic [7:0] QAM_CFG_RST = 8'h00;
   localparam logic [7:0] GAIN_RST = 8'h20;

   localparam int GAIN_FRAC = 5;
   localparam logic [15:0] SAT_POS = 16'h7FFF;
   localparam logic [15:0] SAT_NEG = 16'h8000;

   typedef enum logic [2:0] {
      MAP_B64 = 3'h0,
      MAP_B256 = 3'h1,
      MAP_A16 = 3'h2,
      MAP_A32 = 3'h3,
      MAP_A64 = 3'h4,
      MAP_A128 = 3'h5,
      MAP_A256 = 3'h6,
      MAP_NONE = 3'h7
   } map_mode_t;

   // 12-tap shaping kernels, one row per roll-off code
   localparam logic signed [7:0] PSF_COEF [4][12] = '{
      '{8'h03, 8'hFB, 8'h08, 8'hF2, 8'h1B, 8'h6E,
        8'h6E, 8'h1B, 8'hF2, 8'h08, 8'hFB, 8'h03},
      '{8'h03, 8'hFB, 8'h07, 8'hF3, 8'h1C, 8'h6D,
        8'h6D, 8'h1C, 8'hF3, 8'h07, 8'hFB, 8'h03},
      '{8'h02, 8'hFC, 8'h06, 8'hF4, 8'h1D, 8'h6C,
        8'h6C, 8'h1D, 8'hF4, 8'h06, 8'hFC, 8'h02},
      '{8'h01, 8'hFD, 8'h05, 8'hF6, 8'h1F, 8'h6A,
        8'h6A, 8'h1F, 8'hF6, 8'h05, 8'hFD, 8'h01}
   };

endpackage

// File: core/qam_front_end.sv
`timescale 1ns/100ps
module qam_front_end
   import qam_front_pkg::*;
#(
   parameter int NUM_CH = 4
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic spi_sclk_i,
   input wire logic spi_csn_i,
   input wire logic spi_sdio_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe_o,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [NUM_CH*8-1:0] in_word_i,
   output logic out_valid_o,
   output logic [NUM_CH*16-1:0] out_i_o,
   output logic [NUM_CH*16-1:0] out_q_o
);

   if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
      $error("NUM_CH must lie in 1..16");
   end

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic [9:0] qam_map(input logic [2:0] m,
                                          input logic [7:0] w);
      int a;
      int b;
      int vi;
      int vq;
      a = 0;
      b = 0;
      vi = 0;
      vq = 0;
      unique case (m) // R3
         MAP_B64, MAP_A64: begin // R4 R5
            a = int'({w[4], w[1], w[0]});
            b = int'({w[5], w[3] ~^ w[5], w[2]}); // R7
            vi = 4 * a - 14;
            vq = 4 * b - 14;
         end
         MAP_B256, MAP_A256: begin // R4 R5
            vi = 2 * int'(w[7:4]) - 15;
            vq = 2 * int'(w[3:0]) - 15;
         end
         MAP_A16: begin // R4 R5
            vi = 10 * int'(w[3:2]) - 15;
            vq = 10 * int'(w[1:0]) - 15;
         end
         MAP_A32: begin // R4 R5
            // 6x6 grid less corners: top codes fill the outer rows
            a = int'(w[4:2]);
            b = int'(w[1:0]);
            if (a < 6) begin
               vi = 6 * a - 15;
               vq = 6 * b - 9;
            end else begin
               vi = 6 * b - 9;
               vq = (a == 6) ? -15 : 15;
            end
         end
         MAP_A128: begin // R4 R5
            a = int'(w[6:3]);
            b = int'(w[2:0]);
            if (a < 12) begin
               vi = 2 * a - 11;
               vq = 2 * b - 7;
            end else begin
               vi = 2 * b - 7;
               vq = (a < 14) ? 2 * (a - 12) - 11 : 2 * (a - 14) + 9;
            end
         end
         default: begin
            vi = 0;
            vq = 0;
         end
      endcase
      return {vi[4:0], vq[4:0]}; // R6
   endfunction

   function automatic logic [15:0] in_scale(input logic [7:0] w,
                                            input logic [7:0] g);
      logic signed [17:0] p;
      logic signed [17:0] r;
      p = 18'(signed'(w)) * 18'(signed'({1'b0, g})); // R9
      // round half up before dropping the fraction
      r = (p + 18'sd16) >>> GAIN_FRAC; // R11
      if (r > 18'sd32767) begin
         return SAT_POS; // R11
      end else if (r < -18'sd32768) begin
         return SAT_NEG; // R11
      end
      return r[15:0];
   endfunction

   function automatic logic [15:0] psf(input logic [29:0] h,
                                       input logic [1:0] roll,
                                       input logic ph);
      int acc;
      acc = 0;
      for (int k = 0; k < 6; k++) begin
         acc += int'(signed'(h[k*5 +: 5]))
              * int'(PSF_COEF[roll][2*k + int'(ph)]); // R13
      end
      return acc[15:0];
   endfunction

   // ----------------------------------------
   // serial control port
   // ----------------------------------------
   logic sclk_meta_q, sclk_sync_q, sclk_prev_q;
   logic csn_meta_q, csn_sync_q;
   logic sdio_meta_q, sdio_sync_q;
   logic [3:0] bit_cnt_q, bit_cnt_d;
   logic [14:0] shift_q, shift_d;
   logic [7:0] rd_data_q, rd_data_d;
   logic rd_q, rd_d;
   logic sdo_q, sdo_d;
   logic oe_q, oe_d;
   logic [7:0] dp_en_q, dp_en_d;
   logic [7:0] qam_cfg_q, qam_cfg_d;
   logic [7:0] input_gain_code_q, input_gain_code_d;
   logic ph_q;
   logic sclk_rise, sclk_fall;
   logic [6:0] rd_addr;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] reg_rd;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sclk_meta_q <= 1'b0;
         sclk_sync_q <= 1'b0;
         sclk_prev_q <= 1'b0;
         csn_meta_q <= 1'b1;
         csn_sync_q <= 1'b1;
         sdio_meta_q <= 1'b0;
         sdio_sync_q <= 1'b0;
      end else begin
         sclk_meta_q <= spi_sclk_i;
         sclk_sync_q <= sclk_meta_q;
         sclk_prev_q <= sclk_sync_q;
         csn_meta_q <= spi_csn_i;
         csn_sync_q <= csn_meta_q;
         sdio_meta_q <= spi_sdio_i;
         sdio_sync_q <= sdio_meta_q;
      end
   end

   assign sclk_rise = sclk_sync_q & ~sclk_prev_q;
   assign sclk_fall = ~sclk_sync_q & sclk_prev_q;
   assign rd_addr = {shift_q[5:0], sdio_sync_q};
   assign wr_addr = shift_q[13:7];
   assign wr_data = {shift_q[6:0], sdio_sync_q};

   always_comb begin
      unique case (rd_addr)
         ADDR_DP_EN: reg_rd = dp_en_q;
         ADDR_QAM_CFG: reg_rd = qam_cfg_q;
         ADDR_GAIN: reg_rd = input_gain_code_q;
         ADDR_STATUS: reg_rd = {6'h00, &qam_cfg_q[2:0], ph_q};
         default: reg_rd = 8'h00;
      endcase
   end

   // frame: rw bit, 7-bit address, 8 data bits, msb first
   always_comb begin
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      rd_data_d = rd_data_q;
      rd_d = rd_q;
      sdo_d = sdo_q;
      oe_d = oe_q;
      dp_en_d = dp_en_q;
      qam_cfg_d = qam_cfg_q;
      input_gain_code_d = input_gain_code_q;
      if (csn_sync_q) begin
         bit_cnt_d = 4'h0;
         rd_d = 1'b0;
         oe_d = 1'b0;
      end else if (sclk_rise) begin
         shift_d = {shift_q[13:0], sdio_sync_q};
         bit_cnt_d = bit_cnt_q + 4'h1;
         if (bit_cnt_q == 4'h7) begin
            rd_d = shift_q[6];
            rd_data_d = reg_rd;
         end
         if (bit_cnt_q == 4'hF && !shift_q[14]) begin
            unique case (wr_addr)
               ADDR_DP_EN: dp_en_d = wr_data;
               ADDR_QAM_CFG: qam_cfg_d = wr_data;
               ADDR_GAIN: input_gain_code_d = wr_data;
               default: ;
            endcase
         end
      end else if (sclk_fall) begin
         if (rd_q && bit_cnt_q[3]) begin
            sdo_d = rd_data_q[7];
            rd_data_d = {rd_data_q[6:0], 1'b0};
            oe_d = 1'b1;
         end else begin
            oe_d = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bit_cnt_q <= 4'h0;
         shift_q <= 15'h0000;
         rd_data_q <= 8'h00;
         rd_q <= 1'b0;
         sdo_q <= 1'b0;
         oe_q <= 1'b0;
         dp_en_q <= DP_EN_RST;
         qam_cfg_q <= QAM_CFG_RST;
         input_gain_code_q <= GAIN_RST; // R10
      end else begin
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         rd_data_q <= rd_data_d;
         rd_q <= rd_d;
         sdo_q <= sdo_d;
         oe_q <= oe_d;
         dp_en_q <= dp_en_d;
         qam_cfg_q <= qam_cfg_d;
         input_gain_code_q <= input_gain_code_d;
      end
   end

   assign spi_sdio_o = sdo_q;
   assign spi_sdio_oe_o = oe_q;

   // ----------------------------------------
   // shared sequencing
   // ----------------------------------------
   logic map_en, psf_en, accept;
   logic [2:0] mode;
   logic [1:0] roll;
   logic ph_d;
   logic out_valid_q, out_valid_d;

   // one enable set steers every channel alike
   assign map_en = dp_en_q[MAP_EN_BIT]; // R1
   assign psf_en = dp_en_q[PSF_EN_BIT]; // R14
   assign mode = qam_cfg_q[MODE_LSB +: 3];
   assign roll = qam_cfg_q[ROLL_LSB +: 2];
   // second filter phase blocks the next word, so none is dropped
   assign in_ready_o = ~ph_q; // R17
   assign accept = in_valid_i & ~ph_q;

   always_comb begin
      ph_d = accept & psf_en; // R12
      out_valid_d = accept | ph_q; // R17
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ph_q <= 1'b0;
         out_valid_q <= 1'b0;
      end else begin
         ph_q <= ph_d;
         out_valid_q <= out_valid_d;
      end
   end

   assign out_valid_o = out_valid_q;

   // ----------------------------------------
   // per-channel datapath
   // ----------------------------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [7:0] word;
      logic [9:0] mapped;
      logic [15:0] scaled;
      logic [4:0] fin_i, fin_q;
      logic [29:0] hist_i_q, hist_i_d, hist_q_q, hist_q_d;
      logic [15:0] oi_q, oi_d, oq_q, oq_d;

      assign word = in_word_i[c*8 +: 8];
      assign mapped = qam_map(mode, word); // R2
      assign scaled = in_scale(word, input_gain_code_q); // R9

      always_comb begin
         // bypassed mapper: filter sees the top five bits, real only
         fin_i = map_en ? mapped[9:5] : word[7:3]; // R15
         fin_q = map_en ? mapped[4:0] : 5'h00;
         hist_i_d = hist_i_q;
         hist_q_d = hist_q_q;
         oi_d = oi_q;
         oq_d = oq_q;
         if (accept) begin
            if (psf_en) begin
               hist_i_d = {hist_i_q[24:0], fin_i}; // R14
               hist_q_d = {hist_q_q[24:0], fin_q};
               oi_d = psf(hist_i_d, roll, 1'b0); // R12
               oq_d = psf(hist_q_d, roll, 1'b0);
            end else if (map_en) begin
               // scaler idles while the mapper runs
               oi_d = {{11{mapped[9]}}, mapped[9:5]}; // R8
               oq_d = {{11{mapped[4]}}, mapped[4:0]};
            end else begin
               oi_d = scaled; // R8
               oq_d = 16'h0000;
            end
         end else if (ph_q) begin
            oi_d = psf(hist_i_q, roll, 1'b1); // R12
            oq_d = psf(hist_q_q, roll, 1'b1);
         end
      end

      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            hist_i_q <= 30'h0000_0000;
            hist_q_q <= 30'h0000_0000;
            oi_q <= 16'h0000;
            oq_q <= 16'h0000;
         end else begin
            hist_i_q <= hist_i_d;
            hist_q_q <= hist_q_d;
            oi_q <= oi_d;
            oq_q <= oq_d;
         end
      end

      assign out_i_o[c*16 +: 16] = oi_q;
      assign out_q_o[c*16 +: 16] = oq_q;
   end

endmodule

// File: tb/qam_front_end_assertions.sv
`timescale 1ns/100ps
module qam_front_end_checker
   import qam_front_pkg::*;
#(
   parameter int NUM_CH = 4
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic spi_csn_i,
   input wire logic spi_sdio_oe_o,
   input wire logic in_valid_i,
   input wire logic in_ready_o,
   input wire logic out_valid_o,
   input wire logic [NUM_CH*16-1:0] out_i_o,
   input wire logic [NUM_CH*16-1:0] out_q_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   wire acc = in_valid_i & in_ready_o;
   // ----------------
   // data port and sdio output enable
   // ----------------
   accept_answer_a:
      assert property (acc |=> out_valid_o)
      else $error("no sample after accept");
   phase_follow_a:
      assert property (!in_ready_o |=> out_valid_o && in_ready_o)
      else $error("second filter phase missing");
   ready_cause_a:
      assert property ($fell(in_ready_o) |-> $past(acc))
      else $error("ready dropped without accept");
   pend_out_a:
      assert property (!in_ready_o |-> out_valid_o)
      else $error("pending phase without first sample");
   valid_cause_a:
      assert property (out_valid_o |-> $past(acc) || $past(!in_ready_o))
      else $error("sample without a word");
   out_hold_a:
      assert property (!out_valid_o |-> $stable(out_i_o) && $stable(out_q_o))
      else $error("outputs moved without valid");
   reset_quiet_a:
      assert property (disable iff (1'b0)
         !resetn_i |-> !out_valid_o && in_ready_o && !spi_sdio_oe_o)
      else $error("outputs active in reset");
   oe_release_a:
      assert property (spi_csn_i [*6] |-> !spi_sdio_oe_o)
      else $error("sdio driven while deselected");
   oe_frame_a:
      assert property ($rose(spi_sdio_oe_o) |-> !spi_csn_i)
      else $error("sdio driven outside frame");
   cover property (acc && out_valid_o);
   cover property (!in_ready_o);
   cover property ($rose(spi_sdio_oe_o));
endmodule
bind qam_front_end qam_front_end_checker #(.NUM_CH(NUM_CH)) checker_inst (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .spi_csn_i(spi_csn_i),
   .spi_sdio_oe_o(spi_sdio_oe_o), .in_valid_i(in_valid_i),
   .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
   .out_i_o(out_i_o), .out_q_o(out_q_o));

// File: tb/qam_host_model.sv
`timescale 1ns/100ps
module qam_host_model (
   input wire logic clk_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [31:0] word_o,
   output logic stuck_o
);
   initial begin
      valid_o = 1'b0;
      word_o = 32'h0000_0000;
      stuck_o = 1'b0;
   end
   // ----------------
   // caller enters just after an edge; word held until taken
   // ----------------
   task automatic send(input logic [31:0] w, input logic keep, input int gap);
      int n;
      n = 0;
      repeat (gap) @(posedge clk_i);
      if (gap > 0) #1;
      valid_o = 1'b1;
      word_o = w;
      do begin
         @(posedge clk_i);
         n++;
      end while (!ready_i && n < 50);
      if (!ready_i) stuck_o = 1'b1;
      #1;
      if (!keep) begin
         valid_o = 1'b0;
         word_o = ~w;
      end
   endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
   import qam_front_pkg::*;
();
   logic ref_clk_i = 0, resetn_i = 1, csn = 1, sclk = 0, sdio_d = 0;
   logic sdio_o, sdio_oe, sdio_w, in_valid, in_ready, out_valid, stuck;
   logic [31:0] in_word;
   logic [63:0] out_i, out_q;
   logic [63:0] qi [$], qq [$];
   int num_errors = 0, check_count = 0;
   logic [31:0] sc [5] = '{{8'h20, 8'h80, 16'hFF80}, {8'hFF, 8'h7F, 16'h03F4},
      {8'h1B, 8'h03, 16'h0003}, {8'h1B, 8'hFD, 16'hFFFD},
      {8'h00, 8'h55, 16'h0000}};
   logic [42:0] mp [8] = '{{3'h0, 8'h3F, 16'h000E, 16'h000E},
      {3'h4, 8'hFF, 16'h000E, 16'h000E}, {3'h1, 8'hF0, 16'h000F, 16'hFFF1},
      {3'h6, 8'hF0, 16'h000F, 16'hFFF1}, {3'h2, 8'hF7, 16'hFFFB, 16'h000F},
      {3'h3, 8'hE3, 16'hFFF1, 16'h0009}, {3'h5, 8'h80, 16'hFFF5, 16'hFFF9},
      {3'h7, 8'hFF, 16'h0000, 16'h0000}};
   always #2.5 ref_clk_i = ~ref_clk_i;
   assign sdio_w = sdio_oe ? sdio_o : sdio_d;
   qam_front_end qam_front_end_inst (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk),
      .spi_csn_i(csn), .spi_sdio_i(sdio_w), .spi_sdio_o(sdio_o),
      .spi_sdio_oe_o(sdio_oe), .in_valid_i(in_valid), .in_ready_o(in_ready),
      .in_word_i(in_word), .out_valid_o(out_valid), .out_i_o(out_i),
      .out_q_o(out_q));
   qam_host_model qam_host_model_inst (.clk_i(ref_clk_i), .ready_i(in_ready),
      .valid_o(in_valid), .word_o(in_word), .stuck_o(stuck));
   always @(posedge ref_clk_i) if (out_valid) begin
      qi.push_back(out_i);
      qq.push_back(out_q);
   end
   // ----------------
   // helpers
   // ----------------
   task automatic give_verdict();
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge stuck) begin
      num_errors++;
      give_verdict();
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic chk(input string s, input logic [15:0] e, v);
      check_count++;
      if (v !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", s, e, v);
      end
   endtask
   // sclk half period of 5 clocks keeps clear of the 3-clock sync
   task automatic spi(input logic [15:0] f, output logic [7:0] r);
      csn = 0;
      for (int i = 15; i >= 0; i--) begin
         sdio_d = f[i];
         cyc(5);
         sclk = 1;
         if (i < 8) r[i] = sdio_w;
         cyc(5);
         sclk = 0;
      end
      cyc(5);
      csn = 1;
      cyc(5);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      spi({1'b0, a, d}, r);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e, input string s);
      logic [7:0] r;
      spi({1'b1, a, 8'h00}, r);
      chk(s, {8'h00, e}, {8'h00, r});
   endtask
   task automatic put(input logic [7:0] w, input int gap);
      qam_host_model_inst.send({4{w}}, 1'b0, gap);
   endtask
   task automatic take(input logic [15:0] ei, eq);
      take4({4{ei}}, {4{eq}});
   endtask
   task automatic take4(input logic [63:0] ei, eq);
      logic [63:0] vi, vq;
      check_count++;
      if (qi.size() == 0) begin
         num_errors++;
         $display("BAD out_count exp 1 got 0");
         return;
      end
      vi = qi.pop_front();
      vq = qq.pop_front();
      for (int c = 0; c < 4; c++) begin
         chk("out_i", ei[c*16+:16], vi[c*16+:16]);
         chk("out_q", eq[c*16+:16], vq[c*16+:16]);
      end
   endtask
   // ----------------
   // sequence
   // ----------------
   initial begin
      // a real falling edge, so the async reset clears the X state
      #1;
      resetn_i = 0;
      cyc(8);
      resetn_i = 1;
      cyc(4);
      rd(ADDR_GAIN, 8'h20, "gain_rst");
      rd(ADDR_DP_EN, 8'h00, "dp_en_rst");
      rd(ADDR_QAM_CFG, 8'h00, "cfg_rst");
      rd(7'h20, 8'h00, "unmapped");
      foreach (sc[k]) begin
         wr(ADDR_GAIN, sc[k][31:24]);
         rd(ADDR_GAIN, sc[k][31:24], "gain");
         put(sc[k][23:16], k);
         cyc(2);
         take(sc[k][15:0], 16'h0000);
      end
      wr(ADDR_DP_EN, 8'h80);
      qam_host_model_inst.send({4{8'hDD}}, 1'b1, 0);
      put(8'h3F, 0);
      cyc(2);
      take(16'h0006, 16'hFFF6);
      take(16'h000E, 16'h000E);
      qam_host_model_inst.send({8'h3F, 8'h1D, 8'h3F, 8'hDD}, 1'b0, 0);
      cyc(2);
      take4({16'h000E, 16'h0006, 16'h000E, 16'h0006},
         {16'h000E, 16'hFFF6, 16'h000E, 16'hFFF6});
      foreach (mp[k]) begin
         wr(ADDR_QAM_CFG, {5'h00, mp[k][42:40]});
         put(mp[k][39:32], 0);
         cyc(2);
         take(mp[k][31:16], mp[k][15:0]);
      end
      rd(ADDR_STATUS, 8'h02, "status");
      wr(ADDR_DP_EN, 8'h40);
      wr(ADDR_QAM_CFG, 8'h00);
      wr(ADDR_GAIN, 8'h20);
      repeat (6) put(8'h00, 2);
      cyc(3);
      qi.delete();
      qq.delete();
      put(8'h80, 0);
      cyc(3);
      take(16'(PSF_COEF[0][0] * -16), 16'h0000);
      take(16'(PSF_COEF[0][1] * -16), 16'h0000);
      wr(ADDR_DP_EN, 8'hC0);
      for (int r = 0; r < 4; r++) begin
         wr(ADDR_QAM_CFG, 8'h07);
         // valid held across the burst, released only by the last word
         repeat (5) qam_host_model_inst.send(32'h0000_0000, 1'b1, 0);
         put(8'h00, 0);
         wr(ADDR_QAM_CFG, 8'(r << 4));
         qi.delete();
         qq.delete();
         put(8'h3F, 0);
         cyc(3);
         take(16'(PSF_COEF[r][0] * 14), 16'(PSF_COEF[r][0] * 14));
         take(16'(PSF_COEF[r][1] * 14), 16'(PSF_COEF[r][1] * 14));
      end
      give_verdict();
   end
endmodule
